// [design/scl_pkg.sv]
package scl_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned WAKE_GAP_US = 30;
  localparam int unsigned WAKE_GAP_CYC =
    (WAKE_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] GAP_CNT = 9'(WAKE_GAP_CYC);
  localparam logic [3:0] SCK_HALF = 4'h4; // aclk cycles per sck phase
  // flash command framing
  localparam logic [7:0] OP_WAKE = 8'hab;
  localparam logic [7:0] OP_FREAD = 8'h0b;
  localparam logic [23:0] FLASH_BASE = 24'h000000;
  localparam logic [7:0] DUMMY = 8'h00;
  localparam logic [5:0] WAKE_BITS = 6'h08;
  localparam logic [5:0] READ_BITS = 6'h28;
  localparam logic [5:0] WORD_BITS = 6'h20;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_LEN = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_COUNT = 4'hc;
  // control fields
  localparam int CTRL_MODE = 0; // two bits
  localparam int CTRL_ENC = 2;
  localparam int CTRL_AUTH = 3;
  localparam int CTRL_COMP = 4;
  localparam int CTRL_EXTCLK = 5;
  localparam int CTRL_WIDTH = 8; // three bits, log2 of width
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] LEN_RST = 32'h00000000;
  // status fields
  localparam int STAT_ST = 0; // four bits
  localparam int STAT_ERR = 8; // three bits
  localparam int STAT_USER = 16;
  // modes and widths
  localparam logic [1:0] MODE_ACT = 2'h0;
  localparam logic [1:0] MODE_PAS = 2'h1;
  localparam logic [1:0] MODE_JTAG = 2'h2;
  localparam logic [2:0] W_X16 = 3'h4;
  localparam logic [2:0] W_X32 = 3'h5;
  // jtag instruction codes, values arbitrary
  localparam logic [3:0] JI_IDCODE = 4'h1;
  localparam logic [3:0] JI_STATUS = 4'h2;
  localparam logic [3:0] JI_PROGRAM = 4'h3;
  localparam logic [3:0] JI_BYPASS = 4'hf;
  // error codes
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_COMP = 3'h1;
  localparam logic [2:0] ERR_WIDTH = 3'h2;
  localparam logic [2:0] ERR_OVFL = 3'h3;
  localparam logic [2:0] ERR_AUTH = 3'h4;
  localparam logic [2:0] ERR_MODE = 3'h5;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE, ST_WAKE, ST_GAP, ST_READ_CMD, ST_ACTIVE,
    ST_PASSIVE, ST_JTAG, ST_CHECK, ST_USER, ST_FAIL
  } scl_state_e;

  // pins from outside the aclk domain
  typedef struct packed {
    logic cfg_rst_n;
    logic ext_clk;
    logic miso;
    logic pclk;
    logic pcs_n;
    logic [31:0] pdata;
    logic tck;
    logic tdi;
  } scl_pins_s;

  typedef struct packed {
    scl_pins_s s1, s2, s3;
    scl_state_e st;
    logic [31:0] ctrl, len;
    logic [2:0] err;
    logic [8:0] gap;
    logic [3:0] div;
    logic sck, cs_n, mosi;
    logic [39:0] sh;
    logic [5:0] bits;
    logic [31:0] acc;
    logic [5:0] acc_n;
    logic [1:0][31:0] fifo;
    logic wp, rp;
    logic [1:0] cnt;
    logic [31:0] written;
    logic mem_we;
    logic [31:0] mem_addr, mem_data;
    logic aw_got, w_got;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } scl_state_s;
endpackage

// [design/scl_top.sv]
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - active load wakes the flash before reading
// - at least 30 us from wake to read
// - fast read starts at flash address zero
// - flash clock from oscillator or external pin
// - jtag port can also load the bitstream
// - encrypted words decrypted before being stored
// - authenticated loads need a valid signature
// - carried key hash checked against fuse hash
// - bad signature halts, never user mode
// - encryption and authentication chosen independently
// - no security with compressed bitstreams
// - blocked jtag keeps only id, status, bypass
// - security refuses passive x16 and x32
// - user mode only after memory written
module scl_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // configuration pins
  input wire logic config_reset_n,
  input wire logic external_cfg_clock_pin,
  // flash link
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  // passive link
  input wire logic pas_clk,
  input wire logic pas_cs_n,
  input wire logic [31:0] pas_data,
  // jtag data and decoded instruction
  input wire logic jtag_tck,
  input wire logic jtag_tdi,
  input wire logic [3:0] jtag_instr,
  output logic jtag_allow,
  // fuses
  input wire logic fuse_jtag_block,
  input wire logic [255:0] fuse_pk_hash,
  // crypto engines
  input wire logic [31:0] ks_word,
  input wire logic ks_valid,
  output logic ks_ready,
  output logic [31:0] auth_word,
  output logic auth_valid,
  input wire logic [255:0] pk_hash,
  input wire logic pk_hash_valid,
  input wire logic sig_done,
  input wire logic sig_ok,
  // configuration memory write port
  output logic config_memory_we,
  output logic [31:0] config_memory_addr,
  output logic [31:0] config_memory_wdata,
  // status
  output logic user_mode
);
  scl_pkg::scl_state_s q, d; // whole module state
  scl_pkg::scl_pins_s pins; // raw outside pins
  logic sec, start, itick, tick, stall, ev, push, pop, full;
  logic stream, hash_ok, jtag_prog;
  logic [31:0] ev_bits, head, wdat, wmask;
  logic [5:0] ev_k;

  // fold low k bits of b into the word under assembly
  function automatic logic [31:0] gather(logic [31:0] acc,
      logic [31:0] b, logic [5:0] k);
    logic [31:0] m;
    m = ~({32{1'b1}} << k);
    gather = (k == scl_pkg::WORD_BITS) ? b : ((acc << k) | (b & m));
  endfunction

  assign pins = {config_reset_n, external_cfg_clock_pin, spi_miso,
    pas_clk, pas_cs_n, pas_data, jtag_tck, jtag_tdi};

  // bus handshakes are combinational off held flags
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready = !q.w_got && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign spi_sck = q.sck;
  assign spi_cs_n = q.cs_n;
  assign spi_mosi = q.mosi;
  assign config_memory_we = q.mem_we;
  assign config_memory_addr = q.mem_addr;
  assign config_memory_wdata = q.mem_data;
  assign auth_valid = q.mem_we && q.ctrl[scl_pkg::CTRL_AUTH];
  assign auth_word = q.mem_data;
  assign user_mode = (q.st == scl_pkg::ST_USER);

  // blocked fuse leaves only the three harmless opcodes
  assign jtag_allow = !fuse_jtag_block ||
    jtag_instr == scl_pkg::JI_IDCODE ||
    jtag_instr == scl_pkg::JI_STATUS ||
    jtag_instr == scl_pkg::JI_BYPASS;
  assign jtag_prog = jtag_allow && jtag_instr == scl_pkg::JI_PROGRAM;

  // either security bit, encryption or authentication, makes the load secure
  assign sec = q.ctrl[scl_pkg::CTRL_ENC] ||
    q.ctrl[scl_pkg::CTRL_AUTH];
  // the host owns the reset edge
  assign start = q.s2.cfg_rst_n && !q.s3.cfg_rst_n;
  assign stream = q.st == scl_pkg::ST_ACTIVE ||
    q.st == scl_pkg::ST_PASSIVE || q.st == scl_pkg::ST_JTAG;
  assign full = q.cnt == scl_pkg::FIFO_DEPTH;
  assign head = q.fifo[q.rp];
  // the key never enters here, only the engine keystream
  assign wdat = q.ctrl[scl_pkg::CTRL_ENC] ?
    head ^ ks_word : head;
  // drain one word when the keystream is there, if needed
  assign pop = stream && q.cnt != 2'h0 && q.written != q.len &&
    (!q.ctrl[scl_pkg::CTRL_ENC] || ks_valid);
  assign ks_ready = pop && q.ctrl[scl_pkg::CTRL_ENC];
  assign hash_ok = pk_hash_valid &&
    pk_hash == fuse_pk_hash;
  // full buffer holds the flash clock, no word lost
  assign stall = q.st == scl_pkg::ST_ACTIVE && full;
  assign itick = q.div == 4'h0;
  // flash clock source chosen by software
  assign tick = q.ctrl[scl_pkg::CTRL_EXTCLK] ?
    (q.s2.ext_clk && !q.s3.ext_clk) : itick;

  // one bit-group event per link edge
  always_comb begin
    ev = 1'b0;
    ev_bits = 32'h0;
    ev_k = 6'h01;
    if (q.st == scl_pkg::ST_ACTIVE && tick && !stall && !q.sck) begin
      ev = 1'b1;
      ev_bits = {31'h0, q.s2.miso};
    end else if (q.st == scl_pkg::ST_PASSIVE) begin
      // host is master: its clock, select and data
      ev = q.s2.pclk && !q.s3.pclk && !q.s2.pcs_n;
      ev_bits = q.s2.pdata;
      ev_k = 6'h01 << q.ctrl[scl_pkg::CTRL_WIDTH +: 3];
    end else if (q.st == scl_pkg::ST_JTAG) begin
      // program opcode must be active and not blocked
      ev = q.s2.tck && !q.s3.tck && jtag_prog;
      ev_bits = {31'h0, q.s2.tdi};
    end
    push = ev && (q.acc_n + ev_k == scl_pkg::WORD_BITS);
  end

  // byte-lane mask from the write strobes
  always_comb begin
    wmask = 32'h0;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{q.wstrb[i]}};
    end
  end

  // next state of everything
  always_comb begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.mem_we = 1'b0;
    d.div = itick ? scl_pkg::SCK_HALF - 4'h1 : q.div - 4'h1;
    // write channel, address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = scl_pkg::RESP_OKAY;
      // setup is frozen while words stream and during the check, not in wake, gap or read command
      if (q.awaddr == scl_pkg::REG_CTRL) begin
        if (!stream && q.st != scl_pkg::ST_CHECK) begin
          d.ctrl = (q.ctrl & ~wmask) | (q.wdata & wmask);
        end
      end else if (q.awaddr == scl_pkg::REG_LEN) begin
        if (!stream && q.st != scl_pkg::ST_CHECK) begin
          d.len = (q.len & ~wmask) | (q.wdata & wmask);
        end
      end else if (q.awaddr != scl_pkg::REG_STATUS &&
          q.awaddr != scl_pkg::REG_COUNT) begin
        d.bresp = scl_pkg::RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // read channel
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rdata = 32'h0;
      d.rresp = scl_pkg::RESP_OKAY;
      if (s_axi_araddr == scl_pkg::REG_CTRL) begin
        d.rdata = q.ctrl;
      end else if (s_axi_araddr == scl_pkg::REG_LEN) begin
        d.rdata = q.len;
      end else if (s_axi_araddr == scl_pkg::REG_STATUS) begin
        d.rdata[scl_pkg::STAT_ST +: 4] = q.st;
        d.rdata[scl_pkg::STAT_ERR +: 3] = q.err;
        d.rdata[scl_pkg::STAT_USER] = user_mode;
      end else if (s_axi_araddr == scl_pkg::REG_COUNT) begin
        d.rdata = q.written;
      end else begin
        d.rresp = scl_pkg::RESP_SLVERR;
      end
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    // word assembly into the two-entry buffer
    if (ev) begin
      d.acc = gather(q.acc, ev_bits, ev_k);
      d.acc_n = push ? 6'h00 : q.acc_n + ev_k;
    end
    if (push && !full) begin
      d.fifo[q.wp] = gather(q.acc, ev_bits, ev_k);
      d.wp = !q.wp;
    end
    if (pop) begin
      // memory write carries the clear word
      d.rp = !q.rp;
      d.mem_we = 1'b1;
      d.mem_addr = q.written;
      d.mem_data = wdat;
      d.written = q.written + 32'h1;
    end
    d.cnt = q.cnt + {1'b0, push && !full} - {1'b0, pop};
    // flash shifter: data changes on the falling sck edge
    if ((q.st == scl_pkg::ST_WAKE || q.st == scl_pkg::ST_READ_CMD ||
        q.st == scl_pkg::ST_ACTIVE) && tick && !stall) begin
      d.sck = !q.sck;
      if (q.sck && q.st != scl_pkg::ST_ACTIVE) begin
        d.sh = q.sh << 1;
        d.mosi = q.sh[38];
        d.bits = q.bits - 6'h01;
      end
    end
    case (q.st)
      scl_pkg::ST_IDLE, scl_pkg::ST_USER, scl_pkg::ST_FAIL: begin
        if (start) begin
          d.err = scl_pkg::ERR_NONE;
          d.written = 32'h0;
          d.acc_n = 6'h00;
          d.cnt = 2'h0;
          d.wp = 1'b0;
          d.rp = 1'b0;
          if (sec && q.ctrl[scl_pkg::CTRL_COMP]) begin
            d.st = scl_pkg::ST_FAIL;
            d.err = scl_pkg::ERR_COMP;
          end else if (sec &&
              q.ctrl[scl_pkg::CTRL_MODE +: 2] == scl_pkg::MODE_PAS &&
              q.ctrl[scl_pkg::CTRL_WIDTH +: 3] >= scl_pkg::W_X16) begin
            d.st = scl_pkg::ST_FAIL;
            d.err = scl_pkg::ERR_WIDTH;
          end else if (q.ctrl[scl_pkg::CTRL_WIDTH +: 3] >
              scl_pkg::W_X32) begin
            d.st = scl_pkg::ST_FAIL;
            d.err = scl_pkg::ERR_WIDTH;
          end else if (q.ctrl[scl_pkg::CTRL_MODE +: 2] ==
              scl_pkg::MODE_ACT) begin
            // wake-up opcode goes out first
            d.st = scl_pkg::ST_WAKE;
            d.sh = {scl_pkg::OP_WAKE, 32'h0};
            d.mosi = scl_pkg::OP_WAKE[7];
            d.bits = scl_pkg::WAKE_BITS;
            d.cs_n = 1'b0;
            d.sck = 1'b0;
          end else if (q.ctrl[scl_pkg::CTRL_MODE +: 2] ==
              scl_pkg::MODE_PAS) begin
            // no data check before 32 us; host keeps that gap
            d.st = scl_pkg::ST_PASSIVE;
          end else if (q.ctrl[scl_pkg::CTRL_MODE +: 2] ==
              scl_pkg::MODE_JTAG) begin
            d.st = scl_pkg::ST_JTAG;
          end else begin
            d.st = scl_pkg::ST_FAIL;
            d.err = scl_pkg::ERR_MODE;
          end
        end
      end
      scl_pkg::ST_WAKE: begin
        // last bit shifted: release select, start the gap
        if (d.bits == 6'h00) begin
          d.st = scl_pkg::ST_GAP;
          d.cs_n = 1'b1;
          d.mosi = 1'b0;
          d.gap = scl_pkg::GAP_CNT;
        end
      end
      scl_pkg::ST_GAP: begin
        if (q.gap == 9'h000) begin
          // fast read from address zero, then one dummy byte
          d.st = scl_pkg::ST_READ_CMD;
          d.sh = {scl_pkg::OP_FREAD, scl_pkg::FLASH_BASE,
            scl_pkg::DUMMY};
          d.mosi = scl_pkg::OP_FREAD[7];
          d.bits = scl_pkg::READ_BITS;
          d.cs_n = 1'b0;
          d.sck = 1'b0;
        end else begin
          d.gap = q.gap - 9'h001;
        end
      end
      scl_pkg::ST_READ_CMD: begin
        if (d.bits == 6'h00) begin
          d.st = scl_pkg::ST_ACTIVE;
          d.mosi = 1'b0;
        end
      end
      scl_pkg::ST_ACTIVE, scl_pkg::ST_PASSIVE, scl_pkg::ST_JTAG: begin
        if (push && full) begin
          // passive and jtag sources cannot be held off
          d.st = scl_pkg::ST_FAIL;
          d.err = scl_pkg::ERR_OVFL;
        end else if (q.written == q.len) begin
          d.st = scl_pkg::ST_CHECK;
          d.cs_n = 1'b1;
          d.sck = 1'b0;
        end
      end
      scl_pkg::ST_CHECK: begin
        // all words stored before any verdict counts
        if (!q.ctrl[scl_pkg::CTRL_AUTH]) begin
          d.st = scl_pkg::ST_USER;
        end else if (sig_done) begin
          // engine verdict plus fuse hash match
          if (sig_ok && hash_ok) begin
            d.st = scl_pkg::ST_USER;
          end else begin
            d.st = scl_pkg::ST_FAIL;
            d.err = scl_pkg::ERR_AUTH;
          end
        end
      end
      default: begin
        d.st = scl_pkg::ST_FAIL;
      end
    endcase
    // config reset low aborts and leaves user mode
    if (!q.s2.cfg_rst_n) begin
      d.st = scl_pkg::ST_IDLE;
      d.cs_n = 1'b1;
      d.sck = 1'b0;
    end
  end

  // register the whole state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= scl_pkg::ST_IDLE;
      q.ctrl <= scl_pkg::CTRL_RST;
      q.len <= scl_pkg::LEN_RST;
      q.cs_n <= 1'b1;
      q.s1.cfg_rst_n <= 1'b1;
      q.s2.cfg_rst_n <= 1'b1;
      q.s3.cfg_rst_n <= 1'b1;
      q.s1.pcs_n <= 1'b1;
      q.s2.pcs_n <= 1'b1;
      q.s3.pcs_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_wake_first: assert property (
    q.st == scl_pkg::ST_READ_CMD && $past(q.st) != scl_pkg::ST_READ_CMD
    |-> $past(q.st) == scl_pkg::ST_GAP)
    else $error("read started without wake");
  a_gap_length: assert property (
    q.st == scl_pkg::ST_GAP && $past(q.st) == scl_pkg::ST_WAKE
    |-> ##300 q.st == scl_pkg::ST_GAP && q.cs_n)
    else $error("wake gap too short");
  a_read_addr: assert property (
    $rose(q.st == scl_pkg::ST_READ_CMD) |-> q.sh ==
    {scl_pkg::OP_FREAD, scl_pkg::FLASH_BASE, scl_pkg::DUMMY} && !q.cs_n)
    else $error("bad fast read frame");
  a_no_comp_sec: assert property (
    q.st == scl_pkg::ST_IDLE && start && sec && q.ctrl[scl_pkg::CTRL_COMP]
    && q.s2.cfg_rst_n |=> q.st == scl_pkg::ST_FAIL)
    else $error("secure compressed load accepted");
  a_wide_sec: assert property (
    q.st == scl_pkg::ST_IDLE && start && sec &&
    q.ctrl[scl_pkg::CTRL_MODE +: 2] == scl_pkg::MODE_PAS &&
    q.ctrl[scl_pkg::CTRL_WIDTH +: 3] >= scl_pkg::W_X16
    |=> q.err == scl_pkg::ERR_WIDTH)
    else $error("secure wide passive accepted");
  a_jtag_block: assert property (
    fuse_jtag_block && jtag_instr == scl_pkg::JI_PROGRAM |-> !jtag_allow)
    else $error("blocked jtag opcode allowed");
  a_user_auth: assert property (
    $rose(user_mode) && q.ctrl[scl_pkg::CTRL_AUTH]
    |-> $past(sig_done) && $past(sig_ok) && $past(hash_ok))
    else $error("user mode without good signature");
  a_hash_bad: assert property (
    q.st == scl_pkg::ST_CHECK && q.ctrl[scl_pkg::CTRL_AUTH] && sig_done
    && !hash_ok && q.s2.cfg_rst_n |=> q.st == scl_pkg::ST_FAIL)
    else $error("hash mismatch not rejected");
  a_user_full: assert property (
    $rose(user_mode) |-> q.written == q.len && !q.mem_we)
    else $error("user mode before memory written");
  a_decrypt: assert property (
    pop && q.ctrl[scl_pkg::CTRL_ENC] |=> q.mem_we &&
    (q.mem_data ^ $past(ks_word)) == $past(head))
    else $error("stored word not decrypted");
  c_active_user: cover property (
    $rose(user_mode) && q.ctrl[scl_pkg::CTRL_MODE +: 2] ==
    scl_pkg::MODE_ACT);
  c_passive_user: cover property (
    $rose(user_mode) && q.ctrl[scl_pkg::CTRL_MODE +: 2] ==
    scl_pkg::MODE_PAS);
  c_auth_fail: cover property (q.err == scl_pkg::ERR_AUTH);
endmodule

// [verif/scl_flash_model.sv]
`timescale 1ns/1ps
// serial flash partner: checks framing, serves words after the read
module scl_flash_model (
  // link from the block
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic cfg_rst_n,
  // answers
  output logic spi_miso,
  output logic bad
);
  logic [39:0] cmd; // command shifter
  logic [31:0] w; // word being served
  int nb, frame, k; // bit count, frame count
  realtime t_end; // end of the wake frame
  initial begin
    bad = 1'b0;
    frame = 0;
    spi_miso = 1'b0;
  end
  // new load starts a fresh frame count
  always @(negedge cfg_rst_n) frame = 0;
  // the read must come 30 us or more after the wake frame
  always @(negedge spi_cs_n) begin
    nb = 0;
    cmd = '0;
    if (frame == 1 && $realtime - t_end < 30000.0) bad = 1'b1;
  end
  // first frame must be the lone wake byte
  always @(posedge spi_cs_n) begin
    // reset glitches on the select carry no bits and are no frame
    if (nb != 0) begin
      t_end = $realtime;
      if (frame == 0 && (nb != 8 || cmd[7:0] !== 8'hab))
        bad = 1'b1;
      frame++;
    end
    spi_miso <= ~spi_miso; // released line shows no stale bit
  end
  // command shift on sck rise, read from address zero
  always @(posedge spi_sck) if (!spi_cs_n) begin
    if (nb < 40) cmd = {cmd[38:0], spi_mosi};
    nb++;
    if (frame == 1 && nb == 40 && cmd !== 40'h0b00000000)
      bad = 1'b1;
  end
  // data change on sck fall, msb first; garbage before data phase
  always @(negedge spi_sck) begin
    if (!spi_cs_n && nb >= 40 && frame == 1) begin
      k = nb - 40;
      w = 32'h3c5a96e1 ^ ((k / 32) * 32'h01010101);
      spi_miso = w[31 - k % 32];
    end else spi_miso = ~spi_miso;
  end
endmodule

// [verif/scl_top_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end
module scl_top_tb;
  // bench drive
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic crst = 1, xclk = 0, pclk = 0, pcs = 1, tck = 0, tdi = 0, fblk = 0;
  logic ksv = 0, phv = 1, sd = 1, sok = 1, hold = 0;
  logic [3:0] awa = 0, ara = 0, wst = 0, instr = 0;
  logic [31:0] wd = 0, pd = 0, ksw = 0, ctl = 0, r, e;
  logic [255:0] fh = 0, ph = 0;
  // design outputs
  logic awr, wr, bv, arr, rv, sck, csn, mosi, miso, jal, ksr, av, we, um, fb;
  logic [1:0] br, rr, rs;
  logic [31:0] rd, aw, ma, mwd;
  logic [31:0] src [4]; // words the current load carries
  logic [31:0] kq [$]; // keystream words consumed
  int fail_count = 0, check_count = 0, wn = 0, len = 0, x, i, wl;
  scl_top scl_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(wst), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .config_reset_n(crst), .external_cfg_clock_pin(xclk),
    .spi_sck(sck), .spi_cs_n(csn), .spi_mosi(mosi), .spi_miso(miso),
    .pas_clk(pclk), .pas_cs_n(pcs), .pas_data(pd), .jtag_tck(tck),
    .jtag_tdi(tdi), .jtag_instr(instr), .jtag_allow(jal),
    .fuse_jtag_block(fblk), .fuse_pk_hash(fh), .ks_word(ksw), .ks_valid(ksv),
    .ks_ready(ksr), .auth_word(aw), .auth_valid(av), .pk_hash(ph),
    .pk_hash_valid(phv), .sig_done(sd), .sig_ok(sok),
    .config_memory_we(we), .config_memory_addr(ma),
    .config_memory_wdata(mwd), .user_mode(um));
  scl_flash_model scl_flash_model_i (.spi_sck(sck), .spi_cs_n(csn),
    .spi_mosi(mosi), .cfg_rst_n(crst), .spi_miso(miso), .bad(fb));
  // clocks: 100 ns core, 800 ns external pin
  initial forever #50 aclk = ~aclk;
  initial forever #400 xclk = ~xclk;
  // keystream source, stalls while hold is set
  always @(posedge aclk) begin
    ksv <= !hold && ($urandom % 4 == 0);
    ksw <= $urandom;
  end
  // memory write monitor: decrypted words, order, user mode gating
  always @(negedge aclk) begin
    if (ksr === 1'b1 && ctl[scl_pkg::CTRL_ENC]) kq.push_back(ksw);
    if (we === 1'b1) begin
      e = src[ma[1:0]];
      if (ctl[scl_pkg::CTRL_ENC]) e ^= kq.pop_front();
      `CHK(mwd, e)
      `CHK(ma, 32'(wn))
      if (ctl[scl_pkg::CTRL_AUTH]) `CHK(av, 1'b1)
      wn++;
    end
    if (um === 1'b1) `CHK(wn, len)
  end
  // flash image word i and blocked-port verdict, as the rules give them
  function automatic logic [31:0] fw(input int i);
    return 32'h3c5a96e1 ^ 32'(i * 32'h01010101);
  endfunction
  function automatic logic jok(input logic [3:0] c);
    return c == scl_pkg::JI_IDCODE || c == scl_pkg::JI_STATUS ||
      c == scl_pkg::JI_BYPASS;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 2000) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic pa, pw, ra, rw;
    int n;
    // fresh edge keeps the last release apart from this request
    @(posedge aclk);
    awa <= a; wd <= d; wst <= 4'hf; awv <= 1; wv <= 1; bry <= 1;
    pa = 1; pw = 1; n = 0;
    while ((pa || pw) && n < 2000) begin
      @(negedge aclk); ra = awr; rw = wr; n++;
      @(posedge aclk);
      if (pa && ra) begin awv <= 0; pa = 0; end
      if (pw && rw) begin wv <= 0; pw = 0; end
    end
    do begin @(negedge aclk); n++; end while (bv !== 1'b1 && n < 2000);
    tmo(n);
    rs = br;
    @(posedge aclk); bry <= 0;
  endtask
  task automatic axr(input logic [3:0] a);
    int n;
    @(posedge aclk);
    ara <= a; arv <= 1; rry <= 1; n = 0;
    do begin @(negedge aclk); n++; end while (arr !== 1'b1 && n < 2000);
    @(posedge aclk); arv <= 0;
    do begin @(negedge aclk); n++; end while (rv !== 1'b1 && n < 2000);
    tmo(n);
    r = rd; rs = rr;
    @(posedge aclk); rry <= 0;
  endtask
  // poll status until the state shows up, then check error code
  task automatic wst_t(input scl_pkg::scl_state_e s, input logic [2:0] er);
    int n;
    n = 0;
    do begin axr(scl_pkg::REG_STATUS); repeat (8) @(posedge aclk); n++;
    end while (r[3:0] !== 4'(s) && n < 2000);
    tmo(n);
    `CHK(r[10:8], er)
  endtask
  // configure and pulse the config reset; low aborts, rise starts load
  task automatic go(input logic [31:0] c, input int l);
    axw(scl_pkg::REG_CTRL, c);
    axw(scl_pkg::REG_LEN, 32'(l));
    crst <= 0; repeat (4) @(posedge aclk);
    // new expectations only once the old user mode has dropped
    ctl = c; len = l;
    wn = 0; kq.delete();
    crst <= 1; repeat (6) @(posedge aclk);
  endtask
  // host side: low k bits per edge msb first, upper lines random
  task automatic ser(input logic [31:0] w, input int k, input logic jt);
    for (int b = 32 / k - 1; b >= 0; b--) begin
      pd <= 32'($urandom << k) | 32'((w >> (b * k)) & ((1 << k) - 1));
      tdi <= w[b];
      repeat (6) @(posedge aclk);
      if (jt) tck <= 1; else pclk <= 1;
      repeat (6) @(posedge aclk);
      tck <= 0; pclk <= 0;
    end
  endtask
  initial begin
    void'($urandom(32'hb04c));
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    axr(scl_pkg::REG_CTRL); `CHK(r, scl_pkg::CTRL_RST)
    axr(scl_pkg::REG_LEN); `CHK(r, scl_pkg::LEN_RST)
    axr(4'h2); `CHK({rs, r}, {scl_pkg::RESP_SLVERR, 32'h0})
    axw(4'h6, 32'h1); `CHK(rs, scl_pkg::RESP_SLVERR)
    // refused setups: four security combinations, then too wide and bad mode, one per entry
    for (x = 0; x < 6; x++) begin
      case (x)
        0: go(32'h14, 1); 1: go(32'h18, 1); 2: go(32'h409, 1);
        3: go(32'h505, 1); 4: go(32'h600, 1); default: go(32'h3, 1);
      endcase
      wst_t(scl_pkg::ST_FAIL, x < 2 ? scl_pkg::ERR_COMP :
        x < 5 ? scl_pkg::ERR_WIDTH : scl_pkg::ERR_MODE);
    end
    // active flash loads, oscillator then external pin, buffer stalled
    for (x = 0; x < 2; x++) begin
      for (i = 0; i < 4; i++) src[i] = fw(i);
      hold <= 1;
      go(32'h4 | (x << scl_pkg::CTRL_EXTCLK), 3);
      repeat (2500) @(posedge aclk);
      hold <= 0;
      wst_t(scl_pkg::ST_USER, scl_pkg::ERR_NONE);
      axr(scl_pkg::REG_COUNT); `CHK(r, 32'h3)
      `CHK(fb, 1'b0)
    end
    // passive authenticated loads, random width up to x8: good,
    // bad hash with decryption, then bad signature
    fh <= {8{$urandom}};
    for (x = 0; x < 3; x++) begin
      wl = $urandom % 4;
      for (i = 0; i < 4; i++) src[i] = $urandom;
      go(32'h9 | (wl << scl_pkg::CTRL_WIDTH) |
        ((x & 1) << scl_pkg::CTRL_ENC), 2);
      ph <= fh ^ 256'(x == 1);
      sok <= (x != 2);
      repeat (320) @(posedge aclk);
      pcs <= 0;
      ser(src[0], 1 << wl, 0); ser(src[1], 1 << wl, 0);
      pcs <= 1;
      wst_t(x ? scl_pkg::ST_FAIL : scl_pkg::ST_USER,
        x ? scl_pkg::ERR_AUTH : scl_pkg::ERR_NONE);
      `CHK(um, x == 0)
    end
    // blocked jtag keeps only id, status and bypass
    fblk <= 1;
    for (x = 0; x < 16; x++) begin
      instr <= 4'(x); @(posedge aclk); @(negedge aclk);
      `CHK(jal, jok(4'(x)))
    end
    fblk <= 0; instr <= scl_pkg::JI_PROGRAM;
    src[0] = $urandom;
    go(32'h2, 1);
    ser(src[0], 1, 1);
    wst_t(scl_pkg::ST_USER, scl_pkg::ERR_NONE);
    report_and_stop();
  end
endmodule
